// >>> hdl/usf_frame.sv
`timescale 1ns/100ps
// Functional notes
// - bit 15 at select fall, rest on falls
// - bit 15 shows receive data available
// - bit 14 shows transmit buffer empty
// - command 01 reads configuration back
// - readback bit 13 is queue disable
// - readback bit 12 is shutdown state
// - readback bits 11..8 are interrupt enables
// - readback bits 7..0 framing and baud
// - 7 or 8 data bits, plus parity
// - test bit outputs baud16 on rts
// - command 10 is data write, zeros 13..11
// - bit 10 inhibits send, bit 9 sets rts
// - bit 8 is parity when enabled
// - bits 7..0 character, top ignored if short
// - bit 10 is activity or framing error
// - bit 9 is inverted clear-to-send pin
// - bit 8 is oldest received parity
// - bits 7..0 oldest char, top zero if short
// - command 00 is data read
// - command 11 loads config, returns status only
// - data exchange pops on sixteenth fall
// - write data returns received char too
module usf_frame (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // serial host pins
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic din,
  output logic dout,
  output logic dout_oe,
  // handshake pins and test clock
  input wire logic cts_n,
  input wire logic baud16,
  output logic rts_n,
  output logic tx_force_low,
  // receive side of the uart core
  input wire logic rx_avail,
  input wire usf_pkg::usf_rx_t rx_word,
  input wire logic activity_or_framing_error,
  output logic rx_pop,
  // transmit side of the uart core
  input wire logic tx_buf_empty,
  input wire logic tx_busy,
  output logic tx_load,
  output usf_pkg::usf_tx_t tx_word,
  output logic [3:0] tx_frame_bits,
  // configuration towards the uart core
  output usf_pkg::usf_cfg_t cfg_applied,
  output usf_pkg::usf_cfg_t cfg_written,
  output logic cfg_clear,
  output logic sw_shutdown_state
);

  // data bits per character, plus one when parity is on
  function automatic logic [3:0] char_len(input usf_pkg::usf_cfg_t c);
    logic [3:0] n;
    n = c.short_word ? usf_pkg::SHORT_CHAR_BITS
                     : usf_pkg::LONG_CHAR_BITS;
    if (c.parity_enable) begin
      n = n + usf_pkg::PARITY_EXTRA_BITS;
    end
    return n;
  endfunction

  // top data bit forced low for short words
  function automatic logic [7:0] mask_char(input logic [7:0] ch,
                                           input logic short_word);
    logic [7:0] r;
    r = ch;
    if (short_word) begin
      r[usf_pkg::CHAR_MSB] = 1'b0;
    end
    return r;
  endfunction

  // ---------------------------------------------------------------
  // pin synchronisation
  // ---------------------------------------------------------------
  usf_pkg::usf_pins_t pins_raw;
  usf_pkg::usf_pins_t pins;

  always_comb begin
    pins_raw.cs_n = cs_n;
    pins_raw.sclk = sclk;
    pins_raw.din = din;
    pins_raw.cts_n = cts_n;
    pins_raw.baud16 = baud16;
  end

  usf_sync #(
    .W($bits(usf_pkg::usf_pins_t)),
    .INIT(usf_pkg::PINS_RESET)
  ) u_sync (
    .clk(clk),
    .reset(reset),
    .async_in(pins_raw),
    .sync_out(pins)
  );

  // ---------------------------------------------------------------
  // serial engine
  // ---------------------------------------------------------------
  usf_pkg::usf_state_t state;
  usf_pkg::usf_state_t next_state;
  logic sclk_q;
  logic cs_q;
  logic [4:0] rise_cnt;
  logic [3:0] bit_idx;
  logic [15:0] in_shift;
  logic [15:0] out_word;
  logic [1:0] cmd;
  logic test_active;
  logic next_sclk_q;
  logic next_cs_q;
  logic [4:0] next_rise_cnt;
  logic [3:0] next_bit_idx;
  logic [15:0] next_in_shift;
  logic [15:0] next_out_word;
  logic [1:0] next_cmd;
  logic next_test_active;
  logic next_dout;
  logic next_dout_oe;
  logic next_rx_pop;

  logic cs_fall;
  logic cs_rise;
  logic sclk_rise;
  logic sclk_fall;
  logic frame_done;
  logic [15:0] data_resp;

  always_comb begin
    cs_fall = cs_q & ~pins.cs_n;
    cs_rise = ~cs_q & pins.cs_n;
    sclk_rise = ~sclk_q & pins.sclk & ~pins.cs_n;
    sclk_fall = sclk_q & ~pins.sclk & ~pins.cs_n;
    // only a frame of exactly sixteen clocks has its write carried out
    frame_done = cs_rise && (state == usf_pkg::USF_SHIFT)
                 && (rise_cnt == usf_pkg::FRAME_LEN);
  end

  // data response, also the default until the command is known
  always_comb begin
    data_resp = '0;
    data_resp[usf_pkg::OUT_RX_AVAIL] = rx_avail;
    data_resp[usf_pkg::OUT_TX_EMPTY] = tx_buf_empty;
    data_resp[usf_pkg::IN_TX_INHIBIT] = activity_or_framing_error;
    data_resp[usf_pkg::IN_RTS_ASSERT] = ~pins.cts_n;
    data_resp[usf_pkg::IN_TX_PARITY] = rx_word.rx_parity_value;
    data_resp[usf_pkg::CHAR_MSB:0] =
      mask_char(rx_word.rx_char_bits, cfg_applied.short_word);
  end

  always_comb begin
    next_state = state;
    next_sclk_q = pins.sclk;
    next_cs_q = pins.cs_n;
    next_rise_cnt = rise_cnt;
    next_bit_idx = bit_idx;
    next_in_shift = in_shift;
    next_out_word = out_word;
    next_cmd = cmd;
    next_test_active = test_active;
    next_dout = dout;
    next_dout_oe = dout_oe;
    next_rx_pop = 1'b0;
    if (cs_fall) begin
      next_state = usf_pkg::USF_SHIFT;
      next_rise_cnt = '0;
      next_bit_idx = usf_pkg::TOP_BIT_IDX;
      next_out_word = data_resp;
      next_dout = data_resp[usf_pkg::OUT_RX_AVAIL];
      next_dout_oe = 1'b1;
      next_cmd = usf_pkg::CMD_READ_DATA;
    end else if (cs_rise) begin
      next_state = usf_pkg::USF_IDLE;
      next_dout_oe = 1'b0;
      next_dout = 1'b0;
      next_test_active = 1'b0;
    end else if (state == usf_pkg::USF_SHIFT) begin
      if (sclk_rise) begin
        next_in_shift = {in_shift[14:0], pins.din};
        if (rise_cnt != usf_pkg::RISE_CNT_MAX) begin
          next_rise_cnt = rise_cnt + 5'h01;
        end
        if (rise_cnt == (usf_pkg::CMD_KNOWN_RISES - 5'h01)) begin
          next_cmd = {in_shift[0], pins.din};
          case ({in_shift[0], pins.din})
            usf_pkg::CMD_READ_CFG: begin
              next_out_word[usf_pkg::CFG_MSB:0] = cfg_written;
              next_out_word[usf_pkg::CFG_MSB - 1] =
                cfg_applied.sw_shutdown_request;
            end
            usf_pkg::CMD_WRITE_CFG: begin
              next_out_word[usf_pkg::CFG_MSB:0] = '0;
            end
            default: begin
              // data read or write keeps the data response
              next_out_word = out_word;
            end
          endcase
        end
        // test bit is the last input bit of a readback frame
        if (rise_cnt == usf_pkg::LAST_RISE_BEFORE
            && cmd == usf_pkg::CMD_READ_CFG
            && pins.din) begin
          next_test_active = 1'b1;
        end
      end else if (sclk_fall && rise_cnt != '0) begin
        if (bit_idx != usf_pkg::BOTTOM_BIT_IDX) begin
          next_bit_idx = bit_idx - 4'h1;
          next_dout = out_word[bit_idx - 4'h1];
        end
        // sixteenth fall releases the character just read
        if (rise_cnt == usf_pkg::FRAME_LEN
            && (cmd == usf_pkg::CMD_READ_DATA
                || cmd == usf_pkg::CMD_WRITE_DATA)
            && out_word[usf_pkg::OUT_RX_AVAIL]) begin
          next_rx_pop = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state <= usf_pkg::USF_IDLE;
      sclk_q <= 1'b0;
      cs_q <= 1'b1;
      rise_cnt <= '0;
      bit_idx <= usf_pkg::TOP_BIT_IDX;
      in_shift <= '0;
      out_word <= '0;
      cmd <= usf_pkg::CMD_READ_DATA;
      test_active <= 1'b0;
      dout <= 1'b0;
      dout_oe <= 1'b0;
      rx_pop <= 1'b0;
    end else begin
      state <= next_state;
      sclk_q <= next_sclk_q;
      cs_q <= next_cs_q;
      rise_cnt <= next_rise_cnt;
      bit_idx <= next_bit_idx;
      in_shift <= next_in_shift;
      out_word <= next_out_word;
      cmd <= next_cmd;
      test_active <= next_test_active;
      dout <= next_dout;
      dout_oe <= next_dout_oe;
      rx_pop <= next_rx_pop;
    end
  end

  // ---------------------------------------------------------------
  // command execution and configuration
  // ---------------------------------------------------------------
  logic cfg_pending;
  logic rts_level_n;
  logic next_cfg_pending;
  logic next_rts_level_n;
  usf_pkg::usf_cfg_t next_cfg_written;
  usf_pkg::usf_cfg_t next_cfg_applied;
  usf_pkg::usf_tx_t next_tx_word;
  logic next_tx_load;
  logic next_cfg_clear;
  logic next_rts_n;
  logic next_tx_force_low;
  logic [3:0] next_tx_frame_bits;
  logic [1:0] frame_cmd;

  always_comb begin
    frame_cmd = in_shift[usf_pkg::CMD_MSB:usf_pkg::CMD_LSB];
    next_cfg_pending = cfg_pending;
    next_rts_level_n = rts_level_n;
    next_cfg_written = cfg_written;
    next_cfg_applied = cfg_applied;
    next_tx_word = tx_word;
    next_tx_load = 1'b0;
    next_cfg_clear = 1'b0;
    // all configuration fields, not only framing, wait for the transmitter to go idle
    if (cfg_pending && tx_buf_empty && !tx_busy) begin
      next_cfg_applied = cfg_written;
      next_cfg_pending = 1'b0;
    end
    if (frame_done) begin
      case (frame_cmd)
        usf_pkg::CMD_WRITE_CFG: begin
          next_cfg_written = in_shift[usf_pkg::CFG_MSB:0];
          next_cfg_pending = 1'b1;
          next_cfg_clear = 1'b1;
        end
        usf_pkg::CMD_WRITE_DATA: begin
          next_rts_level_n = ~in_shift[usf_pkg::IN_RTS_ASSERT];
          if (!in_shift[usf_pkg::IN_TX_INHIBIT]) begin
            next_tx_load = 1'b1;
            next_tx_word.tx_parity_value = cfg_applied.parity_enable
              & in_shift[usf_pkg::IN_TX_PARITY];
            next_tx_word.tx_char_bits =
              mask_char(in_shift[usf_pkg::CHAR_MSB:0],
                        cfg_applied.short_word);
          end
        end
        default: begin
          next_cfg_clear = 1'b0;
        end
      endcase
    end
    // test mode replaces the handshake level with the baud clock
    next_rts_n = test_active ? pins.baud16 : next_rts_level_n;
    next_tx_force_low = test_active;
    next_tx_frame_bits = char_len(next_cfg_applied);
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      cfg_pending <= 1'b0;
      rts_level_n <= 1'b1;
      cfg_written <= usf_pkg::CFG_RESET;
      cfg_applied <= usf_pkg::CFG_RESET;
      tx_word <= usf_pkg::TX_RESET;
      tx_load <= 1'b0;
      cfg_clear <= 1'b0;
      rts_n <= 1'b1;
      tx_force_low <= 1'b0;
      tx_frame_bits <= usf_pkg::LONG_CHAR_BITS;
      sw_shutdown_state <= 1'b0;
    end else begin
      cfg_pending <= next_cfg_pending;
      rts_level_n <= next_rts_level_n;
      cfg_written <= next_cfg_written;
      cfg_applied <= next_cfg_applied;
      tx_word <= next_tx_word;
      tx_load <= next_tx_load;
      cfg_clear <= next_cfg_clear;
      rts_n <= next_rts_n;
      tx_force_low <= next_tx_force_low;
      tx_frame_bits <= next_tx_frame_bits;
      sw_shutdown_state <= next_cfg_applied.sw_shutdown_request;
    end
  end

  // readback layout bits 13..0 follow the struct order

endmodule

// >>> hdl/usf_pkg.sv
package usf_pkg;

  // frame geometry
  localparam int FRAME_BITS = 16;
  localparam logic [4:0] FRAME_LEN = 5'h10;
  localparam logic [4:0] CMD_KNOWN_RISES = 5'h02;
  localparam logic [4:0] LAST_RISE_BEFORE = 5'h0F;
  localparam logic [4:0] RISE_CNT_MAX = 5'h1F;
  localparam logic [3:0] TOP_BIT_IDX = 4'hF;
  localparam logic [3:0] BOTTOM_BIT_IDX = 4'h0;

  // command field in frame bits 15..14
  localparam int CMD_MSB = 15;
  localparam int CMD_LSB = 14;
  localparam logic [1:0] CMD_READ_DATA = 2'h0;
  localparam logic [1:0] CMD_READ_CFG = 2'h1;
  localparam logic [1:0] CMD_WRITE_DATA = 2'h2;
  localparam logic [1:0] CMD_WRITE_CFG = 2'h3;

  // input frame fields
  localparam int CFG_MSB = 13;
  localparam int CFG_W = 14;
  localparam int IN_TEST_BIT = 0;
  localparam int IN_TX_INHIBIT = 10;
  localparam int IN_RTS_ASSERT = 9;
  localparam int IN_TX_PARITY = 8;
  localparam int CHAR_MSB = 7;

  // output frame fields
  localparam int OUT_RX_AVAIL = 15;
  localparam int OUT_TX_EMPTY = 14;

  // character framing widths, data bits plus optional parity
  localparam logic [3:0] SHORT_CHAR_BITS = 4'h7;
  localparam logic [3:0] LONG_CHAR_BITS = 4'h8;
  localparam logic [3:0] PARITY_EXTRA_BITS = 4'h1;

  // configuration word, bit 13 down to bit 0
  typedef struct packed {
    logic rx_queue_disable;
    logic sw_shutdown_request;
    logic tx_empty_irq_enable;
    logic rx_avail_irq_enable;
    logic parity_high_irq_enable;
    logic activity_irq_enable;
    logic infrared_timing_enable;
    logic two_stop_select;
    logic parity_enable;
    logic short_word;
    logic [3:0] baud_divisor_select;
  } usf_cfg_t;

  localparam usf_cfg_t CFG_RESET = usf_cfg_t'(14'h0000);

  typedef struct packed {
    logic tx_parity_value;
    logic [7:0] tx_char_bits;
  } usf_tx_t;

  typedef struct packed {
    logic rx_parity_value;
    logic [7:0] rx_char_bits;
  } usf_rx_t;

  localparam usf_tx_t TX_RESET = usf_tx_t'(9'h000);

  // pins after synchronisation
  typedef struct packed {
    logic cs_n;
    logic sclk;
    logic din;
    logic cts_n;
    logic baud16;
  } usf_pins_t;

  // serial clock starts at its idle low level, like its edge detector
  localparam usf_pins_t PINS_RESET = usf_pins_t'(5'h12);

  typedef enum logic {
    USF_IDLE,
    USF_SHIFT
  } usf_state_t;

endpackage

// >>> hdl/usf_sync.sv
`timescale 1ns/100ps
module usf_sync #(
  parameter int W = 5,
  parameter logic [W-1:0] INIT = '0
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // asynchronous levels in, synchronised levels out
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  logic [W-1:0] meta;
  logic [W-1:0] next_meta;
  logic [W-1:0] next_sync_out;

  always_comb begin
    next_meta = async_in;
    next_sync_out = meta;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      meta <= INIT;
      sync_out <= INIT;
    end else begin
      meta <= next_meta;
      sync_out <= next_sync_out;
    end
  end

endmodule

// >>> testbench/usf_frame_props.sv
`timescale 1ns/100ps
module usf_frame_props (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // watched ports
  input wire logic cs_n,
  input wire logic dout_oe,
  input wire logic rx_pop,
  input wire logic tx_load,
  input wire logic [3:0] tx_frame_bits,
  input wire usf_pkg::usf_cfg_t cfg_applied,
  input wire logic cfg_clear,
  input wire logic tx_force_low,
  input wire logic sw_shutdown_state
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  sequence s_idle;
    cs_n [*8];
  endsequence

  sequence s_steady;
    $stable(cfg_applied) [*2];
  endsequence

  a_oe_on_select: assert property ($fell(cs_n) |-> ##[2:5] dout_oe)
    else $error("output enable late after select");
  a_oe_off_idle: assert property (s_idle |-> !dout_oe)
    else $error("output enable stays on between frames");
  a_load_at_end: assert property (tx_load |-> cs_n)
    else $error("transmit load inside a frame");
  a_load_one_pulse: assert property (tx_load |=> !tx_load)
    else $error("transmit load longer than one cycle");
  a_pop_in_frame: assert property (rx_pop |-> !cs_n && dout_oe)
    else $error("receive pop outside a frame");
  a_pop_one_pulse: assert property (rx_pop |=> !rx_pop)
    else $error("receive pop longer than one cycle");
  a_clear_at_end: assert property (cfg_clear |-> cs_n ##1 !cfg_clear)
    else $error("configuration clear misplaced");
  a_char_width: assert property (s_steady |-> tx_frame_bits ==
    (cfg_applied.short_word ? 4'h7 : 4'h8) +
    {3'h0, cfg_applied.parity_enable})
    else $error("character frame width wrong");
  a_shutdown_echo: assert property (s_steady |->
    sw_shutdown_state == cfg_applied.sw_shutdown_request)
    else $error("shutdown state differs from applied setting");
  a_force_in_frame: assert property ($rose(tx_force_low) |-> !cs_n)
    else $error("test mode entered outside a frame");
  a_force_ends: assert property (s_idle |-> !tx_force_low)
    else $error("test mode outlives the frame");
endmodule

bind usf_frame usf_frame_props usf_frame_props_i (
  .clk(clk), .reset(reset), .cs_n(cs_n), .dout_oe(dout_oe),
  .rx_pop(rx_pop), .tx_load(tx_load), .tx_frame_bits(tx_frame_bits),
  .cfg_applied(cfg_applied), .cfg_clear(cfg_clear),
  .tx_force_low(tx_force_low), .sw_shutdown_state(sw_shutdown_state)
);

// >>> testbench/usf_host.sv
`timescale 1ns/100ps
module usf_host (
  // clock
  input wire logic clk,
  // serial link, host side
  output logic cs_n,
  output logic sclk,
  output logic din,
  input wire logic dout
);
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    din = 1'b0;
  end

  // released data line shows a changing pattern between frames
  always @(posedge clk) begin
    if (cs_n) begin
      din <= ~din;
    end
  end

  // msb first, data set after each fall, read just before each rise
  task automatic xfer(input logic [15:0] w, input int n,
                      output logic [15:0] r);
    r = 16'h0000;
    @(posedge clk);
    cs_n <= 1'b0;
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      din <= w[15 - i];
      repeat (2) @(posedge clk);
      @(negedge clk);
      r[15 - i] = dout;
      @(posedge clk);
      sclk <= 1'b1;
      repeat (4) @(posedge clk);
      sclk <= 1'b0;
    end
    repeat (8) @(posedge clk);
    cs_n <= 1'b1;
    repeat (16) @(posedge clk);
  endtask
endmodule

// >>> testbench/usf_frame_bench.sv
`timescale 1ns/100ps
module usf_frame_bench;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic cs_n, sclk, din, dout, dout_oe, rts_n, tx_force_low;
  logic rx_pop, tx_load, cfg_clear, shdn;
  logic cts_n = 1'b1;
  logic baud16 = 1'b0;
  logic rx_avail = 1'b0;
  logic afe = 1'b0;
  logic tx_buf_empty = 1'b1;
  logic tx_busy = 1'b0;
  logic prev_rts = 1'b1;
  usf_pkg::usf_rx_t rx_word = usf_pkg::usf_rx_t'(9'h000);
  usf_pkg::usf_tx_t tx_word;
  usf_pkg::usf_cfg_t cfg_applied, cfg_written;
  logic [3:0] tx_frame_bits;
  logic [15:0] r;
  int fails = 0, samples_checked = 0, cycles = 0;
  int pops = 0, loads = 0, clears = 0, rts_moves = 0;

  always #10 clk = ~clk;

  usf_host usf_host_i (.clk(clk), .cs_n(cs_n), .sclk(sclk), .din(din),
    .dout(dout));

  usf_frame usf_frame_i (
    .clk(clk), .reset(reset), .cs_n(cs_n), .sclk(sclk), .din(din),
    .dout(dout), .dout_oe(dout_oe), .cts_n(cts_n), .baud16(baud16),
    .rts_n(rts_n), .tx_force_low(tx_force_low), .rx_avail(rx_avail),
    .rx_word(rx_word), .activity_or_framing_error(afe), .rx_pop(rx_pop),
    .tx_buf_empty(tx_buf_empty), .tx_busy(tx_busy), .tx_load(tx_load),
    .tx_word(tx_word), .tx_frame_bits(tx_frame_bits),
    .cfg_applied(cfg_applied), .cfg_written(cfg_written),
    .cfg_clear(cfg_clear), .sw_shutdown_state(shdn)
  );

  always @(posedge clk) begin
    baud16 <= ~baud16;
  end

  // pulse counters and the hang limit
  always @(negedge clk) begin
    cycles++;
    pops += int'(rx_pop);
    loads += int'(tx_load);
    clears += int'(cfg_clear);
    rts_moves += int'(tx_force_low && rts_n !== prev_rts);
    prev_rts = rts_n;
    if (cycles == 20000) begin
      fails++;
      wrap_up();
    end
  end

  task set_core(input logic ra, input logic [8:0] rw, input logic fe,
                input logic te, input logic busy, input logic cn);
    @(posedge clk);
    rx_avail <= ra;
    rx_word <= rw;
    afe <= fe;
    tx_buf_empty <= te;
    tx_busy <= busy;
    cts_n <= cn;
  endtask

  task check(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task wrap_up;
    $display("checked %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    // configuration written while a character is still going out
    set_core(1'b1, 9'h1B3, 1'b1, 1'b1, 1'b1, 1'b0);
    usf_host_i.xfer(16'hFA7A, 16, r);
    check(r, 16'hC000);
    check(16'(clears), 16'h0001);
    check({2'h0, cfg_written}, 16'h3A7A);
    usf_host_i.xfer(16'h4000, 16, r);
    check(r, 16'hEA7A);
    set_core(1'b1, 9'h1B3, 1'b1, 1'b1, 1'b0, 1'b0);
    usf_host_i.xfer(16'h4000, 16, r);
    check(r, 16'hFA7A);
    check({15'h0, shdn}, 16'h0001);
    check({2'h0, cfg_applied}, 16'h3A7A);
    // short words (7) plus parity (1) give eight bits per character
    check({12'h0, tx_frame_bits}, 16'h0008);
    $display("test configuration done");
    // short words with parity: load and pop in one exchange
    usf_host_i.xfer(16'h83D5, 16, r);
    check(r, 16'hC733);
    check(16'(pops), 16'h0001);
    check(16'(loads), 16'h0001);
    // parity bit kept, top data bit dropped for short words
    check({7'h0, tx_word}, 16'h0155);
    check({15'h0, rts_n}, 16'h0000);
    // inhibited write only moves the handshake pin
    set_core(1'b0, 9'h05A, 1'b0, 1'b0, 1'b0, 1'b1);
    usf_host_i.xfer(16'h8400, 16, r);
    check(r, 16'h005A);
    check(16'(pops), 16'h0001);
    check(16'(loads), 16'h0001);
    check({15'h0, rts_n}, 16'h0001);
    $display("test write data done");
    // read data consumes the oldest character
    set_core(1'b1, 9'h0FF, 1'b0, 1'b1, 1'b0, 1'b0);
    usf_host_i.xfer(16'h0000, 16, r);
    check(r, 16'hC27F);
    check(16'(pops), 16'h0002);
    // a frame one clock short is ignored
    usf_host_i.xfer(16'h8200, 15, r);
    check(16'(loads), 16'h0001);
    check(16'(pops), 16'h0002);
    check({15'h0, rts_n}, 16'h0001);
    $display("test read and short frame done");
    // test bit puts the baud clock on the handshake pin
    usf_host_i.xfer(16'h4001, 16, r);
    check(r, 16'hFA7A);
    check({15'h0, rts_moves > 1}, 16'h0001);
    $display("test mode done");
    wrap_up();
  end
endmodule
